// ---- rtl/scp_defs.svh ----
// Offsets, field positions, reset values and timing counts of the port.
// Assumes inclusion by bare name from the port module; the package does not include it.
// Operation
// - Configuration writes apply at once, no update.
// - Long instruction bit resets to one.
// - Soft reset restores all registers but configuration.
// - Soft reset bit stays until host clears.
// - LSB first shifts low bit first, address increments.
// - Reset order MSB first, address decrements.
// - Output disable tristates serial out, drives data pin.
// - Output disable clear drives serial out pin.
// - Update bit transfers buffered values, self clears.
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SCP_ADDR_CFG    13'h0000
`define SCP_ADDR_ACNT   13'h0004
`define SCP_ADDR_UPDATE 13'h005A
// ------------------------------------------------------------
// Configuration fields, position within cfg[7:4]; update bit, position within its byte
// ------------------------------------------------------------
`define SCP_CFG_LONG    0
`define SCP_CFG_SRST    1
`define SCP_CFG_LSB     2
`define SCP_CFG_OUTDIS  3
`define SCP_UPD_BIT     0
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define SCP_CFG_RST     4'h1
`define SCP_ACNT_RST    8'h00
`define SCP_INSTR_LAST  4'hF
`define SCP_BYTE_LAST   4'h7
`endif

// ---- rtl/scp_pkg.sv ----
// Types shared by the serial control port.
// Assumes scp_defs.svh holds all numeric constants.
package scp_pkg;
	// Gray along idle, instruction, data, wait
	typedef enum logic [1:0] {
		SCP_IDLE  = 2'b00,
		SCP_INSTR = 2'b01,
		SCP_DATA  = 2'b11,
		SCP_WAIT  = 2'b10
	} scp_state_t;
endpackage

// ---- rtl/scp_regs.sv ----
// Serial control port with configuration and A counter registers.
// Assumes serial pins are asynchronous; sclk halves span 3+ clocks.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"

module scp_regs #(
	parameter int A_W = 6
) (
	input  wire logic           clock,
	input  wire logic           rst_n,
	input  wire logic           serial_clk,
	input  wire logic           chip_sel_n,
	input  wire logic           serial_data_in,
	output logic                serial_data_out,
	output logic                serial_data_oe,
	output logic                serial_out_pin,
	output logic                serial_out_oe,
	output logic [A_W-1:0]      a_count
);
	import scp_pkg::*;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (A_W < 1 || A_W > 8) begin : g_bad_width
		$error("A_W must lie in 1..8");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic             sclk_s1;
		logic             sclk_s2;
		logic             sclk_d;
		logic             csb_s1;
		logic             csb_s2;
		logic             dat_s1;
		logic             dat_s2;
		scp_state_t       state;
		logic [3:0]       bit_cnt;
		logic [15:0]      shreg;
		logic             is_read;
		logic             stream;
		logic [1:0]       left;
		logic [12:0]      addr;
		logic [7:0]       rd_byte;
		logic [3:0]       cfg;
		logic [A_W-1:0]   a_buf;
		logic [A_W-1:0]   a_act;
		logic             sdo_q;
		logic             sdo_en;
		logic             sdio_q;
		logic             sdio_en;
	} scp_regs_state_t;

	scp_regs_state_t st;
	scp_regs_state_t next_st;
	logic            wr_en;
	logic [12:0]     wr_addr;
	logic [7:0]      wr_data;
	logic            rise;
	logic            fall;
	logic            lsb;
	logic [15:0]     sh;
	logic [15:0]     ins;
	logic [12:0]     step_addr;
	logic            out_bit;

	// Unmapped addresses and bits read zero
	function automatic logic [7:0] rd_mux(input logic [12:0] a,
			input logic [3:0] c, input logic [A_W-1:0] v);
		logic [7:0] r;
		r = 8'h00;
		if (a == `SCP_ADDR_CFG)
			r = {c, 4'h0};
		else if (a == `SCP_ADDR_ACNT)
			r = 8'(v);
		return r;
	endfunction

	assign rise = st.sclk_s2 & ~st.sclk_d;
	assign fall = ~st.sclk_s2 & st.sclk_d;
	assign lsb  = st.cfg[`SCP_CFG_LSB];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		wr_en   = 1'b0;
		wr_addr = st.addr;
		wr_data = 8'h00;
		next_st.sclk_s1 = serial_clk;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_d  = st.sclk_s2;
		next_st.csb_s1  = chip_sel_n;
		next_st.csb_s2  = st.csb_s1;
		next_st.dat_s1  = serial_data_in;
		next_st.dat_s2  = st.dat_s1;
		// Same shifter serves instruction and data
		if (lsb)
			sh = {st.dat_s2, st.shreg[15:1]};
		else
			sh = {st.shreg[14:0], st.dat_s2};
		ins = sh;
		// Address walks up for LSB first, down otherwise
		if (lsb)
			step_addr = st.addr + 13'h0001;
		else
			step_addr = st.addr - 13'h0001;
		if (lsb)
			out_bit = st.rd_byte[st.bit_cnt[2:0]];
		else
			out_bit = st.rd_byte[3'h7 - st.bit_cnt[2:0]];
		if (st.csb_s2) begin
			next_st.state   = SCP_IDLE;
			next_st.bit_cnt = 4'h0;
			next_st.sdo_en  = 1'b0;
			next_st.sdio_en = 1'b0;
		end else begin
			case (st.state)
				SCP_IDLE: begin
					next_st.state   = SCP_INSTR;
					next_st.bit_cnt = 4'h0;
				end
				SCP_INSTR: begin
					if (rise) begin
						next_st.shreg   = sh;
						next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
						// Only the 16-bit instruction is decoded
						if (st.bit_cnt == `SCP_INSTR_LAST) begin
							next_st.is_read = ins[15];
							next_st.left    = ins[14:13];
							next_st.stream  = &ins[14:13];
							next_st.addr    = ins[12:0];
							next_st.rd_byte = rd_mux(ins[12:0], st.cfg,
								st.a_act);
							next_st.bit_cnt = 4'h0;
							next_st.state   = SCP_DATA;
						end
					end
				end
				SCP_DATA: begin
					if (fall && st.is_read) begin
						// Pin choice follows output disable
						next_st.sdo_q   = out_bit;
						next_st.sdio_q  = out_bit;
						next_st.sdo_en  = ~st.cfg[`SCP_CFG_OUTDIS];
						next_st.sdio_en = st.cfg[`SCP_CFG_OUTDIS];
					end
					if (rise) begin
						next_st.shreg   = sh;
						next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
						if (st.bit_cnt == `SCP_BYTE_LAST) begin
							wr_en   = ~st.is_read;
							wr_data = lsb ? sh[15:8] : sh[7:0];
							next_st.bit_cnt = 4'h0;
							next_st.addr    = step_addr;
							next_st.rd_byte = rd_mux(step_addr, st.cfg,
								st.a_act);
							if (!st.stream) begin
								next_st.left = 2'(st.left - 2'h1);
								if (st.left == 2'h0)
									next_st.state = SCP_WAIT;
							end
						end
					end
				end
				SCP_WAIT: begin
					// Hold last read bit through its falling edge
					if (fall) begin
						next_st.sdo_en  = 1'b0;
						next_st.sdio_en = 1'b0;
					end
				end
				default: begin
					next_st.state = SCP_IDLE;
				end
			endcase
		end
		if (wr_en) begin
			case (wr_addr)
				`SCP_ADDR_CFG: begin
					// Immediate, no transfer needed
					next_st.cfg = wr_data[7:4];
				end
				`SCP_ADDR_ACNT: begin
					next_st.a_buf = wr_data[A_W-1:0];
				end
				`SCP_ADDR_UPDATE: begin
					// Bit is never stored, so it reads back zero
					if (wr_data[`SCP_UPD_BIT])
						next_st.a_act = st.a_buf;
				end
				default: begin
					next_st.cfg = st.cfg; // Ignored
				end
			endcase
		end
		// Soft reset spares cfg, holds while bit set
		if (st.cfg[`SCP_CFG_SRST]) begin
			next_st.a_buf = A_W'(`SCP_ACNT_RST);
			next_st.a_act = A_W'(`SCP_ACNT_RST);
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st         <= '0;
			st.sclk_s1 <= 1'b0;
			st.csb_s1  <= 1'b1;
			st.csb_s2  <= 1'b1;
			st.state   <= SCP_IDLE;
			st.cfg     <= `SCP_CFG_RST;
			st.a_buf   <= A_W'(`SCP_ACNT_RST);
			st.a_act   <= A_W'(`SCP_ACNT_RST);
		end else begin
			st <= next_st;
		end
	end

	assign serial_out_pin  = st.sdo_q;
	assign serial_out_oe   = st.sdo_en;
	assign serial_data_out = st.sdio_q;
	assign serial_data_oe  = st.sdio_en;
	assign a_count         = st.a_act;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_wr(logic [12:0] a);
		wr_en && wr_addr == a;
	endsequence

	sequence s_byte_step;
		!st.csb_s2 && st.state == SCP_DATA && rise
			&& st.bit_cnt == `SCP_BYTE_LAST;
	endsequence

	property p_cfg_now;
		s_wr(`SCP_ADDR_CFG) |=> st.cfg == $past(wr_data[7:4]);
	endproperty
	a_cfg_now: assert property (p_cfg_now)
		else $error("cfg write not applied next cycle");

	property p_long_kept;
		$fell(st.cfg[`SCP_CFG_LONG]) |->
			$past(wr_en && wr_addr == `SCP_ADDR_CFG && !wr_data[4]);
	endproperty
	a_long_kept: assert property (p_long_kept)
		else $error("long bit cleared without a write");

	property p_srst;
		st.cfg[`SCP_CFG_SRST] |=> st.a_buf == A_W'(`SCP_ACNT_RST)
			&& st.a_act == A_W'(`SCP_ACNT_RST);
	endproperty
	a_srst: assert property (p_srst)
		else $error("soft reset did not restore defaults");

	property p_srst_sticky;
		$fell(st.cfg[`SCP_CFG_SRST]) |-> $past(wr_en
			&& wr_addr == `SCP_ADDR_CFG && !wr_data[5]);
	endproperty
	a_srst_sticky: assert property (p_srst_sticky)
		else $error("soft reset bit cleared by itself");

	property p_addr_up;
		s_byte_step ##0 lsb |=> st.addr == $past(st.addr) + 13'h0001;
	endproperty
	a_addr_up: assert property (p_addr_up)
		else $error("address did not increment");

	property p_addr_down;
		s_byte_step ##0 !lsb |=> st.addr == $past(st.addr) - 13'h0001;
	endproperty
	a_addr_down: assert property (p_addr_down)
		else $error("address did not decrement");

	property p_outdis;
		st.cfg[`SCP_CFG_OUTDIS] && !st.csb_s2 && st.state == SCP_DATA
			&& st.is_read && fall |=> !serial_out_oe && serial_data_oe;
	endproperty
	a_outdis: assert property (p_outdis)
		else $error("serial out pin driven in bidirectional mode");

	property p_outen;
		!st.cfg[`SCP_CFG_OUTDIS] && !st.csb_s2 && st.state == SCP_DATA
			&& st.is_read && fall |=> serial_out_oe && !serial_data_oe;
	endproperty
	a_outen: assert property (p_outen)
		else $error("serial out pin not driven on read");

	property p_update;
		s_wr(`SCP_ADDR_UPDATE) ##0 wr_data[0] && !st.cfg[`SCP_CFG_SRST]
			|=> a_count == $past(st.a_buf);
	endproperty
	a_update: assert property (p_update)
		else $error("update did not transfer buffer");

	property p_unused;
		s_wr(13'h0001) ##0 !st.cfg[`SCP_CFG_SRST] |=>
			$stable(st.a_buf) && $stable(st.cfg);
	endproperty
	a_unused: assert property (p_unused)
		else $error("write to unused register changed state");

endmodule // scp_regs
`default_nettype wire

// ---- tb/scp_host.sv ----
// Host controller model for the serial control port.
// Assumes its tasks are entered just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module scp_host (
	input  wire logic  clock,
	output logic       serial_clk,
	output logic       chip_sel_n,
	output logic       drv_d,
	output logic       drv_en,
	input  wire logic  sdio,
	input  wire logic  data_oe,
	input  wire logic  out_pin,
	input  wire logic  out_oe,
	output logic       rd_v,
	output logic [9:0] rd_b
);
	logic       lsb  = 1'b0;
	logic       odis = 1'b0;
	logic [7:0] sh;
	// ------
	// Frames
	// ------
	initial begin
		serial_clk = 1'b0; // Stands low outside frames
		chip_sel_n = 1'b1;
		drv_d      = 1'b0;
		drv_en     = 1'b0;
		rd_v       = 1'b0;
		rd_b       = 10'h000;
	end
	// Six clocks a half, double the minimum, so read data has settled
	task automatic bitx(input logic w, input logic d, output logic r);
		drv_en <= w;
		drv_d  <= d;
		repeat (6) @(posedge clock);
		r = odis ? sdio : out_pin;
		serial_clk <= 1'b1;
		repeat (6) @(posedge clock);
		serial_clk <= 1'b0;
	endtask
	task automatic xfer(input logic [15:0] ins, input int n,
			input logic [31:0] wd);
		logic r;
		chip_sel_n <= 1'b0;
		for (int i = 0; i < 16; i++) begin // Long form only
			bitx(1'b1, ins[lsb ? i : 15 - i], r);
		end
		for (int k = 0; k < n; k++) begin
			for (int i = 0; i < 8; i++) begin
				bitx(!ins[15], wd[8 * k + (lsb ? i : 7 - i)], r);
				sh[lsb ? i : 7 - i] = r;
			end
			rd_b <= {odis ? data_oe : out_oe, odis ? out_oe : data_oe, sh};
			rd_v <= ins[15];
			@(posedge clock);
			rd_v <= 1'b0;
		end
		chip_sel_n <= 1'b1;
		drv_en     <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
endmodule // scp_host
`default_nettype wire

// ---- tb/serial_port_config_regs_tb_top.sv ----
// Testbench for the serial control port registers.
// Assumes scp_host drives the pins; read results checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs_tb_top;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        sclk, csn, dd, den, dout, doe, sop, soe, rv;
	logic        tog = 1'b0;
	logic [9:0]  rb;
	logic [5:0]  a_count;
	logic [31:0] seed = 32'hFB10F036;
	logic [9:0]  exq[$];
	int          err_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	wire logic   sdio;
	// ------
	// Wiring
	// ------
	// Released pin toggles so a stale level never passes
	assign sdio = doe ? dout : (den ? dd : tog);
	initial forever #20 clock = ~clock;
	always @(posedge clock) tog <= ~tog;
	scp_regs #(.A_W(6)) dut (.clock(clock), .rst_n(rst_n),
		.serial_clk(sclk), .chip_sel_n(csn), .serial_data_in(sdio),
		.serial_data_out(dout), .serial_data_oe(doe),
		.serial_out_pin(sop), .serial_out_oe(soe), .a_count(a_count));
	scp_host h (.clock(clock), .serial_clk(sclk), .chip_sel_n(csn),
		.drv_d(dd), .drv_en(den), .sdio(sdio), .data_oe(doe),
		.out_pin(sop), .out_oe(soe), .rd_v(rv), .rd_b(rb));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk_rd(input logic [9:0] e, input logic [9:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_a(input logic [5:0] e, input logic [5:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Note expected read bytes, with the pin enables, then run the frame
	task automatic go(input logic r, input logic [12:0] a, input int n,
			input logic [15:0] d);
		for (int k = 0; k < n; k++) begin
			if (r) exq.push_back({2'b10, d[8 * k +: 8]});
		end
		h.xfer({r, 2'(n - 1), a}, n, {16'h0000, d});
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (rv === 1'b1) chk_rd(exq.pop_front(), rb);
		if (cyc == 30000) begin
			err_count++;
			print_verdict();
		end
	end
	// ------
	// Sequence
	// ------
	initial begin
		logic [7:0] v;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		go(1, 13'h000, 1, 16'h0010);
		for (int i = 1; i < 4; i++) begin
			seed = xs(seed);
			go(0, 13'(i), 1, {8'h00, seed[7:0]});
			go(1, 13'(i), 1, 16'h0000);
		end
		seed = xs(seed);
		v = seed[7:0] | 8'h01;
		go(0, 13'h004, 1, {8'h00, v});
		go(1, 13'h004, 1, 16'h0000);
		chk_a(6'h00, a_count);
		go(0, 13'h05A, 1, 16'h0001);
		chk_a(v[5:0], a_count);
		go(1, 13'h05A, 1, 16'h0000);
		go(1, 13'h004, 2, {10'h000, v[5:0]});
		go(0, 13'h000, 1, {12'h005, seed[11:8]});
		h.lsb = 1'b1;
		go(1, 13'h003, 2, {2'b00, v[5:0], 8'h00});
		go(1, 13'h000, 1, 16'h0050);
		go(0, 13'h000, 1, 16'h00D0);
		h.odis = 1'b1;
		go(1, 13'h004, 1, {10'h000, v[5:0]});
		go(0, 13'h000, 1, 16'h00F0);
		chk_a(6'h00, a_count);
		go(0, 13'h004, 1, 16'h003F);
		go(0, 13'h05A, 1, 16'h0001);
		chk_a(6'h00, a_count);
		go(1, 13'h000, 1, 16'h00F0);
		go(0, 13'h000, 1, 16'h00D0); // Host ends soft reset
		go(1, 13'h000, 1, 16'h00D0);
		go(1, 13'h004, 1, 16'h0000);
		repeat (4) @(posedge clock);
		print_verdict();
	end
endmodule // serial_port_config_regs_tb_top
`default_nettype wire
